// ### shared/prc_pkg.sv
// Package of constants and types for the reset, interrupt and test-mode control block.
`default_nettype none
package prc_pkg;
   // Reference clock rate and the power-up hold-off time.
   localparam int REF_CLK_HZ = 50_000_000;
   localparam int REF_CLK_NS = 20;
   localparam int HOLDOFF_US_X10 = 25;
   // Hold-off in cycles: 2.5 ms at 20 ns, rounded up.
   localparam int HOLDOFF_CYCLES = (HOLDOFF_US_X10 * 100_000 + REF_CLK_NS - 1) / REF_CLK_NS;
   localparam int HOLD_W = 18;
   // Bit position of the interrupt enable in management register 17.
   localparam int IRQ_EN_BIT = 15;
   localparam int MGMT_IRQ_REG = 17;
   // Sequencer states.
   typedef enum logic [1:0] {
      PRC_HOLD,
      PRC_RUN
   } prc_state_t;
endpackage : prc_pkg
`default_nettype wire

// ### rtl/prc_phy_reset_irq_control.sv
// Reset hold-off sequencer, open-drain status interrupt and test-mode select.
`default_nettype none
// How it works
// - Low chip reset resets all logic.
// - Operational only 2.5 ms after reset release.
// - Interrupt pin used only when enable set.
// - Interrupt pin is open drain only.
// - Test enable high selects test mode.

// The chip reset clears every flop at once, without waiting for a clock edge.
// Once it rises, a counter holds the block out of service for the power
// settling time. The count comes from the package and may be shortened by the
// parameter for quick runs, but a real part must keep the full figure.
// All pin inputs cross into the clock domain through two flops each. The
// status pins are treated as one word. A skew of one cycle between them can
// show as two changes, which only raises the same interrupt twice.
// Status changes seen during the hold-off are folded into the baseline, so the
// first status after power-up never raises an interrupt by itself.
// The interrupt pin is open drain: the data bit is tied low and only the
// enable moves. Clearing the enable drops any pending request, so a host that
// turns the interrupt back on starts from a clean state.
// If a change and a service arrive in the same cycle the change wins, so an
// event is never lost to a late acknowledge.
// The interrupt stays asserted until serviced; a level service input simply
// clears it in each cycle it is held, unless a new change sets it in that cycle.
// Test mode follows its pin after the same two-flop crossing.
module prc_phy_reset_irq_control
   import prc_pkg::*;
#(
   parameter int HOLDOFF = HOLDOFF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic irq_enable,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic irq_service,
   input wire logic test_enable,
   output logic operational,
   output logic test_mode,
   output logic status_change_irq_out_o,
   output logic status_change_irq_out_oe
);
   // Sequencer state and hold-off counter.
   prc_state_t state;
   logic [HOLD_W-1:0] hold_count;
   // Synchroniser stages, previous status word and the latched request.
   logic [2:0] stat_s1;
   logic [2:0] stat_s2;
   logic [2:0] stat_last;
   logic [1:0] ctl_s1;
   logic [1:0] ctl_s2;
   logic irq_pending;
   logic test_s1;
   logic test_s2;

   // Hold-off ends when the counter reaches the last cycle.
   wire hold_done = (hold_count == HOLD_W'(HOLDOFF - 1));
   wire [2:0] stat_now = stat_s2;
   wire status_change = operational && (stat_now != stat_last);
   wire irq_enabled = ctl_s2[0];
   wire irq_serviced = ctl_s2[1];

   // Synchronise all pins; the first stage feeds only the second.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_s1 <= 3'h0;
         stat_s2 <= 3'h0;
         ctl_s1 <= 2'h0;
         ctl_s2 <= 2'h0;
         test_s1 <= 1'b0;
         test_s2 <= 1'b0;
      end else begin
         stat_s1 <= {link_up, speed_100, full_duplex};
         stat_s2 <= stat_s1;
         ctl_s1 <= {irq_service, irq_enable};
         ctl_s2 <= ctl_s1;
         test_s1 <= test_enable;
         test_s2 <= test_s1;
      end
   end

   // Hold-off sequencer; the delay lets supplies settle before use.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PRC_HOLD;
         hold_count <= HOLD_W'(0);
      end else begin
         case (state)
            PRC_HOLD: begin
               hold_count <= hold_count + HOLD_W'(1);
               if (hold_done) begin
                  state <= PRC_RUN;
               end
            end
            default: begin
               state <= PRC_RUN;
            end
         endcase
      end
   end

   // Sticky interrupt: a new change wins over a service in the same cycle.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending <= 1'b0;
         stat_last <= 3'h0;
      end else begin
         // Track the status word every cycle so that only fresh changes count.
         stat_last <= stat_now;
         if (status_change && irq_enabled) begin
            irq_pending <= 1'b1;
         end else if (irq_serviced || !irq_enabled) begin
            irq_pending <= 1'b0;
         end
      end
   end

   // Outputs; the pad only ever pulls low, an external resistor pulls high.
   always_comb begin
      operational = (state == PRC_RUN);
      test_mode = test_s2;
      status_change_irq_out_o = 1'b0;
      status_change_irq_out_oe = irq_pending && irq_enabled;
   end

   // Reset checks. They carry no disable clause, since they must see the
   // cycles in which the chip reset is low.
   a_reset_hold: assert property (@(posedge ref_clk)
      !rst_n
      |-> ##1 !operational)
      else $error("Operational right after reset.");
   a_reset_count: assert property (@(posedge ref_clk)
      !rst_n
      |-> ##1 (hold_count == HOLD_W'(0)))
      else $error("Hold-off counter not cleared by reset.");

   // Hold-off checks: the run state comes exactly at the end of the count
   // and is kept until the next chip reset.
   a_holdoff_early: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(operational)
      |-> ($past(hold_count) == HOLD_W'(HOLDOFF - 1)))
      else $error("Operational before the hold-off count ended.");
   a_holdoff_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state == PRC_HOLD && hold_done)
      |=> operational)
      else $error("Hold-off did not end on count.");
   a_run_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      operational
      |=> operational)
      else $error("Operational dropped without reset.");
   a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state == PRC_HOLD)
      |=> (hold_count == HOLD_W'($past(hold_count) + 1)))
      else $error("Hold-off counter skipped a cycle.");
   a_quiet_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !operational
      |-> !status_change_irq_out_oe)
      else $error("Interrupt driven during hold-off.");

   // Interrupt pin checks: enable gating and the open-drain form.
   a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !irq_enabled
      |-> !status_change_irq_out_oe)
      else $error("Interrupt driven while disabled.");
   a_irq_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !irq_enabled
      |=> !irq_pending)
      else $error("Request kept while disabled.");
   a_od_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1
      |-> (status_change_irq_out_o == 1'b0))
      else $error("Interrupt pin driven high.");
   a_od_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !irq_pending
      |-> !status_change_irq_out_oe)
      else $error("Interrupt pin pulled with no request.");

   // Test mode follows the pin two edges late in both directions.
   a_test_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(test_mode)
      |-> $past(test_enable, 2))
      else $error("Test mode entered with pin low.");
   a_test_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(test_mode)
      |-> !$past(test_enable, 2))
      else $error("Test mode left with pin high.");

   // Sticky request: set on change, held until serviced, cleared by service.
   a_irq_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (status_change && irq_enabled)
      |=> irq_pending)
      else $error("Status change lost.");
   a_irq_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (irq_pending && irq_enabled && !irq_serviced)
      |=> irq_pending)
      else $error("Interrupt dropped unserviced.");
   a_irq_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (irq_serviced && !status_change)
      |=> !irq_pending)
      else $error("Service did not clear the request.");

   // Main scenarios: run, raise, service, test mode and a change racing a service.
   c_run: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(operational));
   c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(status_change_irq_out_oe));
   c_service: cover property (@(posedge ref_clk) disable iff (!rst_n)
      irq_pending ##1 !irq_pending);
   c_test: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(test_mode));
   c_set_wins: cover property (@(posedge ref_clk) disable iff (!rst_n)
      status_change && irq_enabled && irq_serviced);
endmodule : prc_phy_reset_irq_control
`default_nettype wire

// ### test/prc_host_model.sv
// Host model: reset source with clock pre-run and pulled-up interrupt line.
`default_nettype none
module prc_host_model (
   input wire logic ref_clk,
   input wire logic rst_req,
   input wire logic irq_o,
   input wire logic irq_oe,
   output logic rst_n,
   output wire logic irq_line
);
   timeunit 1ns;
   timeprecision 1ns;
   int pre;
   // The pull-up gives the idle level whenever the device lets go.
   assign irq_line = irq_oe ? irq_o : 1'b1;
   // Release only once ten clocks have run, so the reset is complete.
   always @(negedge ref_clk or posedge rst_req) begin
      if (rst_req) begin
         pre <= 0;
         rst_n <= 1'b0;
      end else if (pre < 10) begin
         pre <= pre + 1;
      end else begin
         rst_n <= 1'b1;
      end
   end
endmodule : prc_host_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the reset, interrupt and test-mode block.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HO = 20;
   logic ref_clk = 1'b0, rst_req = 1'b1, en = 1'b0, link = 1'b0, spd = 1'b0, dup = 1'b0;
   logic svc = 1'b0, tst = 1'b0, rst_n, oper, tmode, irq_o, irq_oe;
   wire logic irq_line;
   int fail_count = 0, check_count = 0;
   // Free-running 50 MHz clock.
   always #10 ref_clk = ~ref_clk;
   prc_host_model host (.ref_clk(ref_clk), .rst_req(rst_req), .irq_o(irq_o),
      .irq_oe(irq_oe), .rst_n(rst_n), .irq_line(irq_line));
   prc_phy_reset_irq_control #(.HOLDOFF(HO)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .irq_enable(en), .link_up(link), .speed_100(spd), .full_duplex(dup),
      .irq_service(svc), .test_enable(tst), .operational(oper), .test_mode(tmode),
      .status_change_irq_out_o(irq_o), .status_change_irq_out_oe(irq_oe));
   task automatic chk(string what, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   // A bounded wait; running out of cycles ends the run as a failure.
   task automatic wait_line(logic val, int n);
      int i;
      for (i = 0; i < n && irq_line !== val; i++) @(negedge ref_clk);
      chk("irq_line", val, irq_line);
      if (irq_line !== val) final_report();
   endtask : wait_line
   task automatic t_reset();
      int i;
      @(negedge ref_clk);
      rst_req = 1'b1;
      #1 chk("operational", 1'b0, oper);
      repeat (6) @(negedge ref_clk);
      chk("irq_oe", 1'b0, irq_oe);
      rst_req <= 1'b0;
      for (i = 0; i < 40 && rst_n !== 1'b1; i++) @(negedge ref_clk);
      chk("rst_n", 1'b1, rst_n);
      if (rst_n !== 1'b1) final_report();
      repeat (HO - 2) @(negedge ref_clk);
      chk("operational", 1'b0, oper);
      repeat (4) @(negedge ref_clk);
      chk("operational", 1'b1, oper);
      $display("reset test done");
   endtask : t_reset
   task automatic t_irq();
      en = 1'b1;
      repeat (3) @(negedge ref_clk);
      link = 1'b1;
      wait_line(1'b0, 8);
      chk("irq_o", 1'b0, irq_o);
      repeat (6) @(negedge ref_clk);
      chk("irq_line", 1'b0, irq_line);
      svc = 1'b1;
      wait_line(1'b1, 6);
      svc = 1'b0;
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_off();
      en = 1'b0;
      repeat (3) @(negedge ref_clk);
      spd = 1'b1;
      dup = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk("irq_line", 1'b1, irq_line);
      $display("disabled test done");
   endtask : t_off
   task automatic t_test();
      tst = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("test_mode", 1'b1, tmode);
      tst = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("test_mode", 1'b0, tmode);
      $display("test mode test done");
   endtask : t_test
   // Main sequence; the second reset lands in mid-run.
   initial begin
      t_reset();
      t_irq();
      t_off();
      t_test();
      t_reset();
      final_report();
   end
   // Watchdog against a hang anywhere in the sequence.
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
